// ### src/wdt_pkg.sv
/*
  Constants shared by the watchdog / interval timer channel: bus addresses,
  write keys, control/status field positions, reset values and hold counts.
  Assumes a 16-bit processor bus with byte-wide reads and word-wide writes.
*/
package wdt_pkg;

  localparam logic [15:0] WRITE_ADDR = 16'hFFA8;
  localparam logic [15:0] CSR_READ_ADDR = 16'hFFA8;
  localparam logic [15:0] COUNT_READ_ADDR = 16'hFFA9;

  localparam logic [7:0] KEY_COUNT = 8'h5A;
  localparam logic [7:0] KEY_CSR = 8'hA5;

  // control/status field positions
  localparam int OVF_BIT = 7;
  localparam int MODE_BIT = 6;
  localparam int RUN_BIT = 5;
  localparam int PSS_BIT = 4;
  localparam int ACTION_BIT = 3;
  localparam int CKS_LSB = 0;

  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [2:0] CKS_RESET = 3'h0;

  // clk cycles the next increment is held after a main-to-sub change
  localparam logic [15:0] SWITCH_DELAY_CYCLES = 16'h0002;

endpackage

// ### src/count_prescaler.sv
/*
  Count clock prescaler: divides the main clock, or counts sub-clock ticks,
  and emits a one-cycle tick for the selected division.
  Assumes sub_tick is a one-cycle pulse already synchronous to clk.
*/
`timescale 1ns/1ps
module count_prescaler
  import wdt_pkg::*;
#(
  parameter int MAIN_W = 17,
  parameter int SUB_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_sync_n,
  // selection
  input wire logic use_sub,
  input wire logic [2:0] clock_select,
  input wire logic sub_tick,
  // output
  output logic count_tick
);

  logic [MAIN_W-1:0] main_cnt_reg;
  logic [SUB_W-1:0] sub_cnt_reg;

  // division mask for the main clock: divide by mask + 1
  function automatic logic [MAIN_W-1:0] main_mask(input logic [2:0] sel);
    unique case (sel)
      3'h0: main_mask = MAIN_W'(17'h0_0001);
      3'h1: main_mask = MAIN_W'(17'h0_003F);
      3'h2: main_mask = MAIN_W'(17'h0_007F);
      3'h3: main_mask = MAIN_W'(17'h0_01FF);
      3'h4: main_mask = MAIN_W'(17'h0_07FF);
      3'h5: main_mask = MAIN_W'(17'h0_1FFF);
      3'h6: main_mask = MAIN_W'(17'h0_7FFF);
      3'h7: main_mask = MAIN_W'(17'h1_FFFF);
    endcase
  endfunction

  wire logic [MAIN_W-1:0] mmask = main_mask(clock_select);
  wire logic [SUB_W-1:0] smask = SUB_W'((8'h02 << clock_select) - 8'h01);
  wire logic main_hit = (main_cnt_reg & mmask) == mmask;
  wire logic sub_hit = sub_tick && ((sub_cnt_reg & smask) == smask);
  // the last sub-clock choice is a main clock /256 division
  wire logic slow_main_hit = main_cnt_reg[7:0] == 8'hFF;
  wire logic tick_next = !use_sub ? main_hit :
                         (clock_select == 3'h7) ? slow_main_hit : sub_hit;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      main_cnt_reg <= '0;
      sub_cnt_reg <= '0;
      count_tick <= 1'b0;
    end else begin
      main_cnt_reg <= main_cnt_reg + MAIN_W'(1);
      if (sub_tick) begin
        sub_cnt_reg <= sub_cnt_reg + SUB_W'(1);
      end
      count_tick <= tick_next;
    end
  end

endmodule

// ### src/watchdog_interval_timer.sv
/*
  Watchdog / interval timer channel: 8-bit up-counter, control/status
  register, keyed word writes on one shared address, overflow interrupt,
  NMI and reset requests, and count holds across clock mode changes.
  Assumes a processor bus that presents one access per clk cycle and
  holds settle_time_select stable across a sub-to-main transition.
*/
`timescale 1ns/1ps
module watchdog_interval_timer
  import wdt_pkg::*;
#(
  parameter int SETTLE_BASE = 256,
  parameter bit SECOND_CHANNEL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // processor bus
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_word,
  input wire logic bus_read,
  output logic [7:0] bus_rdata,
  // clock sources and power mode
  input wire logic sub_tick,
  input wire logic clock_mode_sub,
  input wire logic [2:0] settle_time_select,
  // requests
  output logic interval_overflow_irq,
  output logic nmi_request,
  output logic reset_request
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers and decode

  logic overflow_flag_reg;
  logic timer_mode_select_reg;
  logic timer_run_reg;
  logic prescale_sub_reg;
  logic reset_action_reg;
  logic [2:0] count_clock_select_reg;
  logic [7:0] watchdog_count_reg;
  logic mode_sub_prev_reg;
  logic [15:0] hold_reg;
  logic count_tick;

  // byte writes never reach a register
  wire logic write_hit = bus_write && bus_word && (bus_addr == WRITE_ADDR);
  wire logic key_count = write_hit && (bus_wdata[15:8] == KEY_COUNT);
  wire logic key_csr = write_hit && (bus_wdata[15:8] == KEY_CSR);
  // other upper bytes fall through both keys untouched

  wire logic [7:0] csr_value = {overflow_flag_reg, timer_mode_select_reg,
                                timer_run_reg, prescale_sub_reg,
                                reset_action_reg, count_clock_select_reg};

  // clock select and mode are loaded even while running; software must
  // stop the timer first or the count may slip
  wire logic run_next = key_csr ? bus_wdata[RUN_BIT] : timer_run_reg;
  wire logic mode_next = key_csr ? bus_wdata[MODE_BIT] : timer_mode_select_reg;

  //////////////////////////////////////////////////////////////////////////////
  // clock mode holds for the second channel

  wire logic to_sub = SECOND_CHANNEL && clock_mode_sub && !mode_sub_prev_reg;
  wire logic to_main = SECOND_CHANNEL && !clock_mode_sub && mode_sub_prev_reg;
  wire logic hold_active = hold_reg != 16'h0000;
  wire logic [15:0] settle_cycles = 16'(SETTLE_BASE) << settle_time_select;
  wire logic [15:0] hold_next =
      to_sub ? SWITCH_DELAY_CYCLES :
      to_main ? settle_cycles :
      hold_active ? hold_reg - 16'h0001 : 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // counter

  count_prescaler #(
    .MAIN_W(17),
    .SUB_W(7)
  ) u_prescaler (
    .clk(clk),
    .rst_sync_n(rst_sync_reg),
    .use_sub(prescale_sub_reg),
    .clock_select(count_clock_select_reg),
    .sub_tick(sub_tick),
    .count_tick(count_tick)
  );

  // a keyed counter write in the same cycle as a tick swallows the tick
  wire logic increment = timer_run_reg && count_tick && !hold_active &&
                         !key_count;
  wire logic wrap = increment && (watchdog_count_reg == COUNT_MAX);
  wire logic [7:0] count_next =
      !run_next ? COUNT_RESET :
      key_count ? bus_wdata[7:0] :
      increment ? watchdog_count_reg + 8'h01 : watchdog_count_reg;

  // set wins over a clear in the same cycle; writing one is ignored
  wire logic ovf_next = wrap ? 1'b1 :
      (key_csr && !bus_wdata[OVF_BIT]) ? 1'b0 :
      overflow_flag_reg;

  wire logic nmi_next = wrap && timer_mode_select_reg &&
                        !reset_action_reg;
  wire logic reset_next = wrap && timer_mode_select_reg &&
                          reset_action_reg;
  // interrupt follows the flag itself, only in interval mode
  wire logic irq_next = ovf_next && !mode_next;

  wire logic [7:0] read_next =
      (bus_addr == CSR_READ_ADDR) ? csr_value :
      (bus_addr == COUNT_READ_ADDR) ? watchdog_count_reg : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      overflow_flag_reg <= 1'b0;
      timer_mode_select_reg <= 1'b0;
      timer_run_reg <= 1'b0;
      prescale_sub_reg <= 1'b0;
      reset_action_reg <= 1'b0;
      count_clock_select_reg <= CKS_RESET;
      watchdog_count_reg <= COUNT_RESET;
    end else begin
      if (key_csr) begin
        timer_mode_select_reg <= bus_wdata[MODE_BIT];
        timer_run_reg <= bus_wdata[RUN_BIT];
        prescale_sub_reg <= bus_wdata[PSS_BIT];
        reset_action_reg <= bus_wdata[ACTION_BIT];
        count_clock_select_reg <= bus_wdata[CKS_LSB+2:CKS_LSB];
      end
      overflow_flag_reg <= ovf_next;
      watchdog_count_reg <= count_next;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mode_sub_prev_reg <= 1'b0;
      hold_reg <= 16'h0000;
      bus_rdata <= 8'h00;
      interval_overflow_irq <= 1'b0;
      nmi_request <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      mode_sub_prev_reg <= clock_mode_sub;
      hold_reg <= hold_next;
      if (bus_read) begin
        bus_rdata <= read_next;
      end
      interval_overflow_irq <= irq_next;
      nmi_request <= nmi_next;
      reset_request <= reset_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_reg);

  sequence s_count_write;
    bus_write && bus_word && bus_addr == WRITE_ADDR &&
    bus_wdata[15:8] == KEY_COUNT && timer_run_reg &&
    !(key_csr);
  endsequence

  count_key_a: assert property (
    s_count_write |=> watchdog_count_reg == $past(bus_wdata[7:0]))
    else $error("keyed counter write not loaded");

  write_wins_a: assert property (
    (s_count_write and count_tick) |=>
      watchdog_count_reg == $past(bus_wdata[7:0]))
    else $error("increment overrode counter write");

  csr_key_a: assert property (
    key_csr |=> timer_run_reg == $past(bus_wdata[RUN_BIT]) &&
      count_clock_select_reg == $past(bus_wdata[2:0]))
    else $error("keyed control write not loaded");

  byte_write_a: assert property (
    (bus_write && !bus_word && !count_tick && !to_sub && !to_main) |=>
      $stable(csr_value[6:0]))
    else $error("byte write changed control register");

  no_key_a: assert property (
    (write_hit && !key_count && !key_csr && !timer_run_reg) |=>
      $stable(watchdog_count_reg) && $stable(csr_value[6:0]))
    else $error("unkeyed write changed a register");

  stop_zero_a: assert property (
    !timer_run_reg |-> watchdog_count_reg == COUNT_RESET)
    else $error("stopped counter not zero");

  wrap_flag_a: assert property (
    wrap |=> overflow_flag_reg && watchdog_count_reg == 8'h00 [*1])
    else $error("wrap did not set overflow flag");

  irq_flag_a: assert property (
    interval_overflow_irq == (overflow_flag_reg && !timer_mode_select_reg))
    else $error("interrupt does not follow overflow flag");

  nmi_path_a: assert property (
    (wrap && timer_mode_select_reg && !reset_action_reg) |=>
      nmi_request && !reset_request ##1 !nmi_request)
    else $error("watchdog overflow without single NMI pulse");

  flag_one_a: assert property (
    (overflow_flag_reg && key_csr && bus_wdata[OVF_BIT]) |=> overflow_flag_reg)
    else $error("writing one cleared overflow flag");

  sub_hold_a: assert property (
    to_sub |=> !increment [*2])
    else $error("increment not held after sub-clock change");

  read_csr_a: assert property (
    (bus_read && bus_addr == CSR_READ_ADDR) |=>
      bus_rdata == $past(csr_value))
    else $error("control read returned wrong value");

endmodule

// ### verification/cpu_bus_model.sv
/*
  Processor-side bus model: word and byte writes to the shared write
  address and byte reads, one access at a time.
  Assumes the timer samples requests on the rising edge of clk.
*/
`timescale 1ns/1ps
module cpu_bus_model
  import wdt_pkg::*;
(
  // clock
  input wire logic clk,
  // bus
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_write,
  output logic bus_word,
  output logic bus_read,
  input wire logic [7:0] bus_rdata
);
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
    bus_write = 1'b0;
    bus_word = 1'b0;
    bus_read = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // key in the upper byte, data in the lower byte
  task automatic wr(input logic [15:0] d, input logic word);
    @(posedge clk);
    bus_addr <= WRITE_ADDR;
    bus_wdata <= d;
    bus_word <= word;
    bus_write <= 1'b1;
    @(posedge clk);
    bus_write <= 1'b0;
    // write data is not held once the write has been taken
    bus_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clk);
    bus_read <= 1'b0;
    bus_addr <= ~a;
    #1 d = bus_rdata;
  endtask
endmodule

// ### verification/tb_top.sv
/*
  Self-checking bench for the watchdog / interval timer channel.
  Assumes the bus model above and a shortened settle hold in simulation.
*/
`timescale 1ns/1ps
module tb_top;
  import wdt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] bus_addr;
  logic [15:0] bus_wdata;
  logic bus_write;
  logic bus_word;
  logic bus_read;
  logic [7:0] bus_rdata;
  logic irq;
  logic nmi;
  logic rst_req;
  logic [7:0] rv;
  logic [2:0] seen;
  logic clock_mode_sub = 1'b0;
  logic [2:0] settle_sel = 3'h0;
  int fail_count = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  watchdog_interval_timer #(.SETTLE_BASE(4), .SECOND_CHANNEL(1'b1)) dut (
    .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_word(bus_word), .bus_read(bus_read),
    .bus_rdata(bus_rdata), .sub_tick(1'b0),
    .clock_mode_sub(clock_mode_sub),
    .settle_time_select(settle_sel), .interval_overflow_irq(irq),
    .nmi_request(nmi), .reset_request(rst_req)
  );
  cpu_bus_model cpu (
    .clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_word(bus_word), .bus_read(bus_read),
    .bus_rdata(bus_rdata)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  // gathers {reset, nmi, irq} over 40 cycles, long enough for FE to wrap
  task automatic watch(output logic [2:0] s);
    s = 3'h0;
    repeat (40) begin
      @(posedge clk);
      #1 s = s | {rst_req, nmi, irq};
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_access;
    cpu.rd(CSR_READ_ADDR, rv); chk(rv, 8'h00);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, 8'h00);
    // slowest main division keeps the count still while it is read
    cpu.wr(16'hA527, 1'b1);
    cpu.rd(CSR_READ_ADDR, rv); chk(rv, 8'h27);
    cpu.wr(16'h5AF0, 1'b1);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, 8'hF0);
    cpu.wr(16'h5A11, 1'b0);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, 8'hF0);
    cpu.wr(16'h3311, 1'b1);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, 8'hF0);
    cpu.rd(CSR_READ_ADDR, rv); chk(rv, 8'h27);
    cpu.wr(16'hA507, 1'b1);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, 8'h00);
    $display("test access done");
  endtask
  task automatic t_interval;
    cpu.wr(16'hA520, 1'b1);
    cpu.wr(16'h5AFE, 1'b1);
    watch(seen); chk({5'h00, seen}, 8'h01);
    cpu.rd(CSR_READ_ADDR, rv); chk(rv, 8'hA0);
    cpu.wr(16'hA5A0, 1'b1);
    cpu.rd(CSR_READ_ADDR, rv); chk(rv, 8'hA0);
    cpu.wr(16'hA520, 1'b1);
    cpu.rd(CSR_READ_ADDR, rv); chk(rv, 8'h20);
    chk({7'h00, irq}, 8'h00);
    cpu.wr(16'hA500, 1'b1);
    $display("test interval done");
  endtask
  task automatic t_watchdog;
    cpu.wr(16'hA560, 1'b1);
    cpu.wr(16'h5AFE, 1'b1);
    watch(seen); chk({5'h00, seen}, 8'h02);
    cpu.wr(16'hA500, 1'b1);
    cpu.wr(16'hA568, 1'b1);
    cpu.wr(16'h5AFE, 1'b1);
    watch(seen); chk({5'h00, seen}, 8'h04);
    cpu.wr(16'hA500, 1'b1);
    $display("test watchdog done");
  endtask
  // div 2 counting: reads two cycles apart differ by one unless held
  task automatic t_clock_mode;
    logic [7:0] base;
    cpu.wr(16'hA520, 1'b1);
    cpu.rd(COUNT_READ_ADDR, base);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, base + 8'h01);
    @(posedge clk);
    clock_mode_sub <= 1'b1;
    settle_sel <= 3'h1;
    cpu.rd(COUNT_READ_ADDR, base);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, base);
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, base + 8'h01);
    // settle hold is 4 << 1 = 8 cycles with the bench's shortened base
    @(posedge clk);
    clock_mode_sub <= 1'b0;
    cpu.rd(COUNT_READ_ADDR, base);
    repeat (4) begin
      cpu.rd(COUNT_READ_ADDR, rv); chk(rv, base);
    end
    cpu.rd(COUNT_READ_ADDR, rv); chk(rv, base + 8'h01);
    cpu.wr(16'hA500, 1'b1);
    $display("test clock mode done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_access();
    t_interval();
    t_watchdog();
    t_clock_mode();
    print_verdict();
  end
  // all tests take well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
